// ==== inc/rpc_defines.svh ====
/*
 Codec constants: header geometry, field widths, version codes, limits.
 Assumes a byte-wide link, MSB first.
*/
// Operation
// - one bit marks control or data
// - 24-bit channel id separates streams
// - spare bits in two field groups
// - vendor flag selects vendor interpretation
// - 5-bit protocol code, vendor when flagged
// - nine static protocols, rest for expansion
// - reply flag marks request or response
// - ack sequence honoured only when flagged
// - 5-bit command code in every header
// - 16-bit length locates PDU boundaries
// - lengths up to 64000 bytes supported
// - 16-bit per-channel sequence detects gaps; code checks only consecutive headers on one channel
// - 16-bit ack sequence for flow control
// - 32-bit time stamp flags late packets
// - no origin flag, no sub-channel field
// - host sets up channels on request
// - 3-bit version, one is standard
// - unordered flag permits UDP transport
// - 3-bit priority per PDU
`ifndef RPC_DEFINES_SVH
`define RPC_DEFINES_SVH

`define RPC_HDR_BYTES      5'h11
`define RPC_HDR_LAST_IDX   5'h10
`define RPC_W_VERSION      3
`define RPC_W_PRIO         3
`define RPC_W_VC_ID        24
`define RPC_W_SPARE_A      2
`define RPC_W_SPARE_B      9
`define RPC_W_CODE         5
`define RPC_W_WORD         16
`define RPC_W_STAMP        32
`define RPC_VERSION_STD    3'h1
`define RPC_VERSION_PRE    3'h0
`define RPC_NUM_STATIC     5'h09
`define RPC_MAX_PDU_LEN    16'hFA00

`endif

// ==== inc/rpc_pkg.sv ====
/*
 Types for the remoting PDU header codec. Assumes rpc_defines.svh.
*/
`include "rpc_defines.svh"

package rpc_pkg;

   // packed order is the wire order, most significant bit first
   typedef struct packed {
      logic [`RPC_W_VERSION-1:0] version;
      logic                      unordered;
      logic [`RPC_W_PRIO-1:0]    prio;
      logic                      control_data_flag;
      logic [`RPC_W_VC_ID-1:0]   vc_id;
      logic [`RPC_W_SPARE_A-1:0] spare_a;
      logic                      vendor_extension_flag;
      logic [`RPC_W_CODE-1:0]    payload_protocol_code;
      logic [`RPC_W_SPARE_B-1:0] spare_b;
      logic                      reply_flag;
      logic                      ack_valid_flag;
      logic [`RPC_W_CODE-1:0]    command;
      logic [`RPC_W_WORD-1:0]    length;
      logic [`RPC_W_WORD-1:0]    seq;
      logic [`RPC_W_WORD-1:0]    ack_seq;
      logic [`RPC_W_STAMP-1:0]   channel_time_stamp;
   } rpc_hdr_t;

   typedef enum logic [4:0] {
      RPC_PROTO_DISPLAY  = 5'h00,
      RPC_PROTO_VIDEO    = 5'h01,
      RPC_PROTO_AUDIO    = 5'h02,
      RPC_PROTO_KEYBOARD = 5'h03,
      RPC_PROTO_POINTER  = 5'h04,
      RPC_PROTO_USB_CTRL = 5'h05,
      RPC_PROTO_USB_INT  = 5'h06,
      RPC_PROTO_USB_ISO  = 5'h07,
      RPC_PROTO_USB_BULK = 5'h08
   } rpc_proto_t;

   typedef enum logic [1:0] {
      RPC_TX_IDLE = 2'h0,
      RPC_TX_HDR  = 2'h1,
      RPC_TX_PAY  = 2'h3
   } rpc_tx_state_t;

   typedef enum logic {
      RPC_RX_HDR = 1'h0,
      RPC_RX_PAY = 1'h1
   } rpc_rx_state_t;

endpackage

// ==== inc/rpc_byte_if.sv ====
/*
 Byte carrier between the codec's modules.
 Assumes one clock; a byte moves when valid and ready are high.
*/
`timescale 1ns/1ps

interface rpc_byte_if;
   logic       valid;
   logic       ready;
   logic       last;
   logic [7:0] data;

   modport src (output valid, output data, output last, input ready);
   modport snk (input valid, input data, input last, output ready);
endinterface

// ==== core/rpc_tx_ser.sv ====
/*
 Header serializer: shifts a loaded header out a byte at a time,
 most significant byte first. Assumes load only while idle.
*/
`timescale 1ns/1ps
`include "rpc_defines.svh"

module rpc_tx_ser (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              load,
   input  rpc_pkg::rpc_hdr_t      hdr,
   rpc_byte_if.src                out
);
   logic [$bits(rpc_pkg::rpc_hdr_t)-1:0] sh;
   logic [4:0]                           left;

   assign out.valid = (left != 5'h00);
   assign out.data  = sh[$bits(rpc_pkg::rpc_hdr_t)-1 -: 8];
   assign out.last  = (left == 5'h01);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sh   <= '0;
         left <= 5'h00;
      end else if (load) begin
         sh   <= hdr;
         left <= `RPC_HDR_BYTES;
      end else if (out.valid && out.ready) begin
         sh   <= {sh[$bits(rpc_pkg::rpc_hdr_t)-9:0], 8'h00};
         left <= left - 5'h01;
      end
   end
endmodule // rpc_tx_ser

// ==== core/rpc_rx_track.sv ====
/*
 Per-stream order tracker: remembers the last channel, sequence and stamp
 seen and flags gaps and late arrivals. Assumes one stb per header.
*/
`timescale 1ns/1ps
`include "rpc_defines.svh"

module rpc_rx_track (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    stb,
   input  wire logic [`RPC_W_VC_ID-1:0] vc_id,
   input  wire logic [`RPC_W_WORD-1:0]  seq,
   input  wire logic [`RPC_W_STAMP-1:0] stamp,
   output logic                         seq_gap,
   output logic                         ts_late
);
   logic                     seen;
   logic [`RPC_W_VC_ID-1:0]  last_vc;
   logic [`RPC_W_WORD-1:0]   last_seq;
   logic [`RPC_W_STAMP-1:0]  last_stamp;
   logic                     same;
   logic [`RPC_W_STAMP-1:0]  diff;

   // only one stream is remembered; a channel switch restarts tracking
   assign same = seen && (vc_id == last_vc);
   assign diff = stamp - last_stamp;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seen       <= 1'b0;
         last_vc    <= '0;
         last_seq   <= '0;
         last_stamp <= '0;
         seq_gap    <= 1'b0;
         ts_late    <= 1'b0;
      end else if (stb) begin
         seen       <= 1'b1;
         last_vc    <= vc_id;
         last_seq   <= seq;
         last_stamp <= stamp;
         seq_gap    <= same && (seq != last_seq + 16'h0001);
         // wrap-safe compare: a backwards step marks the packet late
         ts_late    <= same && diff[`RPC_W_STAMP-1];
      end
   end
endmodule // rpc_rx_track

// ==== core/rpc_codec.sv ====
/*
 PDU header codec top: builds outgoing headers ahead of their payload,
 and parses incoming bytes into header fields and payload.
 Assumes link and user sides on clk; one output byte of buffering
 each way, back-pressure passes straight through.
*/
`timescale 1ns/1ps
`include "rpc_defines.svh"

module rpc_codec (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // transmit request
   input  wire logic                    tx_start,
   input  wire logic                    tx_unordered,
   input  wire logic [`RPC_W_PRIO-1:0]  tx_prio,
   input  wire logic                    tx_control_data_flag,
   input  wire logic [`RPC_W_VC_ID-1:0] tx_vc_id,
   input  wire logic                    tx_vendor_extension_flag,
   input  wire logic [`RPC_W_CODE-1:0]  tx_payload_protocol_code,
   input  wire logic                    tx_reply_flag,
   input  wire logic                    tx_ack_valid_flag,
   input  wire logic [`RPC_W_CODE-1:0]  tx_command,
   input  wire logic [`RPC_W_WORD-1:0]  tx_length,
   input  wire logic [`RPC_W_WORD-1:0]  tx_seq,
   input  wire logic [`RPC_W_WORD-1:0]  tx_ack_seq,
   input  wire logic [`RPC_W_STAMP-1:0] tx_channel_time_stamp,
   output logic                         tx_busy,
   output logic                         tx_len_err,
   // transmit payload
   input  wire logic                    tx_pay_valid,
   input  wire logic [7:0]              tx_pay_data,
   output logic                         tx_pay_ready,
   // link out
   output logic                         link_tx_valid,
   output logic [7:0]                   link_tx_data,
   output logic                         link_tx_last,
   input  wire logic                    link_tx_ready,
   // link in
   input  wire logic                    link_rx_valid,
   input  wire logic [7:0]              link_rx_data,
   output logic                         link_rx_ready,
   // received header
   output logic                         rx_hdr_valid,
   output logic [`RPC_W_VERSION-1:0]    rx_version,
   output logic                         rx_unordered,
   output logic [`RPC_W_PRIO-1:0]       rx_prio,
   output logic                         rx_control_data_flag,
   output logic [`RPC_W_VC_ID-1:0]      rx_vc_id,
   output logic                         rx_vendor_extension_flag,
   output logic [`RPC_W_CODE-1:0]       rx_payload_protocol_code,
   output logic                         rx_reply_flag,
   output logic                         rx_ack_valid_flag,
   output logic [`RPC_W_CODE-1:0]       rx_command,
   output logic [`RPC_W_WORD-1:0]       rx_length,
   output logic [`RPC_W_WORD-1:0]       rx_seq,
   output logic [`RPC_W_WORD-1:0]       rx_ack_seq,
   output logic [`RPC_W_STAMP-1:0]      rx_channel_time_stamp,
   output logic                         rx_ver_err,
   output logic                         rx_proto_unknown,
   output logic                         rx_len_err,
   output logic                         rx_seq_gap,
   output logic                         rx_ts_late,
   // received payload
   output logic                         rx_pay_valid,
   output logic [7:0]                   rx_pay_data,
   output logic                         rx_pay_last,
   input  wire logic                    rx_pay_ready
);

   function automatic logic len_ok(input logic [`RPC_W_WORD-1:0] len);
      len_ok = (len <= `RPC_MAX_PDU_LEN);
   endfunction

   // version forced, spares zeroed, ack number cleared when not flagged
   function automatic rpc_pkg::rpc_hdr_t clean_hdr(input rpc_pkg::rpc_hdr_t h);
      rpc_pkg::rpc_hdr_t c;
      c         = h;
      c.version = `RPC_VERSION_STD;
      c.spare_a = '0;
      c.spare_b = '0;
      if (!h.ack_valid_flag) begin
         c.ack_seq = '0;
      end
      clean_hdr = c;
   endfunction

   // transmit side

   rpc_pkg::rpc_tx_state_t tx_state;
   rpc_pkg::rpc_hdr_t      tx_hdr_in;
   rpc_byte_if             ser_bus ();
   logic                   ser_load;
   logic [`RPC_W_WORD-1:0] tx_left;
   logic                   tx_take;
   logic                   tx_accept;

   // no origin flag or sub-channel field exists to fill
   always_comb begin
      tx_hdr_in                       = '0;
      tx_hdr_in.unordered             = tx_unordered;
      tx_hdr_in.prio                  = tx_prio;
      tx_hdr_in.control_data_flag     = tx_control_data_flag;
      tx_hdr_in.vc_id                 = tx_vc_id;
      tx_hdr_in.vendor_extension_flag = tx_vendor_extension_flag;
      tx_hdr_in.payload_protocol_code = tx_payload_protocol_code;
      tx_hdr_in.reply_flag            = tx_reply_flag;
      tx_hdr_in.ack_valid_flag        = tx_ack_valid_flag;
      tx_hdr_in.command               = tx_command;
      tx_hdr_in.length                = tx_length;
      tx_hdr_in.seq                   = tx_seq;
      tx_hdr_in.ack_seq               = tx_ack_seq;
      tx_hdr_in.channel_time_stamp    = tx_channel_time_stamp;
   end

   assign tx_accept = tx_start && (tx_state == rpc_pkg::RPC_TX_IDLE);
   assign ser_load  = tx_accept && len_ok(tx_length);
   assign tx_busy   = (tx_state != rpc_pkg::RPC_TX_IDLE);

   // the output byte register may load whenever it is empty or draining
   assign tx_take       = !link_tx_valid || link_tx_ready;
   assign ser_bus.ready = (tx_state == rpc_pkg::RPC_TX_HDR) && tx_take;
   assign tx_pay_ready  = (tx_state == rpc_pkg::RPC_TX_PAY) && tx_take;

   rpc_tx_ser u_ser (
      .clk   (clk),
      .rst_n (rst_n),
      .load  (ser_load),
      .hdr   (clean_hdr(tx_hdr_in)),
      .out   (ser_bus.src)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_len_err <= 1'b0;
      end else begin
         // oversize requests are refused and reported, never truncated
         tx_len_err <= tx_accept && !len_ok(tx_length);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_state <= rpc_pkg::RPC_TX_IDLE;
         tx_left  <= '0;
      end else begin
         unique case (tx_state)
            rpc_pkg::RPC_TX_IDLE: begin
               if (ser_load) begin
                  tx_state <= rpc_pkg::RPC_TX_HDR;
                  tx_left  <= tx_length;
               end
            end
            rpc_pkg::RPC_TX_HDR: begin
               if (ser_bus.valid && ser_bus.ready && ser_bus.last) begin
                  tx_state <= (tx_left == '0) ? rpc_pkg::RPC_TX_IDLE
                                              : rpc_pkg::RPC_TX_PAY;
               end
            end
            rpc_pkg::RPC_TX_PAY: begin
               if (tx_pay_valid && tx_pay_ready) begin
                  tx_left <= tx_left - 16'h0001;
                  if (tx_left == 16'h0001) begin
                     tx_state <= rpc_pkg::RPC_TX_IDLE;
                  end
               end
            end
            default: tx_state <= rpc_pkg::RPC_TX_IDLE;
         endcase
      end
   end

   // link output register, fed by header bytes then payload bytes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link_tx_valid <= 1'b0;
         link_tx_data  <= 8'h00;
         link_tx_last  <= 1'b0;
      end else if (tx_take) begin
         if (ser_bus.valid && ser_bus.ready) begin
            link_tx_valid <= 1'b1;
            link_tx_data  <= ser_bus.data;
            link_tx_last  <= ser_bus.last && (tx_left == '0);
         end else if (tx_pay_valid && tx_pay_ready) begin
            link_tx_valid <= 1'b1;
            link_tx_data  <= tx_pay_data;
            link_tx_last  <= (tx_left == 16'h0001);
         end else begin
            link_tx_valid <= 1'b0;
            link_tx_last  <= 1'b0;
         end
      end
   end

   // receive side

   rpc_pkg::rpc_rx_state_t                rx_state;
   logic [$bits(rpc_pkg::rpc_hdr_t)-1:0]  rx_sh;
   logic [$bits(rpc_pkg::rpc_hdr_t)-1:0]  next_rx_sh;
   rpc_pkg::rpc_hdr_t                     rx_hdr_now;
   logic [4:0]                            rx_cnt;
   logic [`RPC_W_WORD-1:0]                rx_left;
   logic                                  rx_take;
   logic                                  rx_done;
   logic                                  rx_hdr_stb;

   assign rx_take = link_rx_valid && link_rx_ready;
   // header bytes are never stalled; payload waits on the consumer
   assign link_rx_ready = (rx_state == rpc_pkg::RPC_RX_HDR) ||
                          !rx_pay_valid || rx_pay_ready;
   assign next_rx_sh = {rx_sh[$bits(rpc_pkg::rpc_hdr_t)-9:0], link_rx_data};
   assign rx_hdr_now = next_rx_sh;
   assign rx_done    = (rx_cnt == `RPC_HDR_LAST_IDX);
   assign rx_hdr_stb = rx_take && (rx_state == rpc_pkg::RPC_RX_HDR) && rx_done;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_state <= rpc_pkg::RPC_RX_HDR;
         rx_sh    <= '0;
         rx_cnt   <= 5'h00;
         rx_left  <= '0;
      end else if (rx_take) begin
         unique case (rx_state)
            rpc_pkg::RPC_RX_HDR: begin
               rx_sh <= next_rx_sh;
               if (rx_done) begin
                  rx_cnt  <= 5'h00;
                  rx_left <= rx_hdr_now.length;
                  if (rx_hdr_now.length != '0) begin
                     rx_state <= rpc_pkg::RPC_RX_PAY;
                  end
               end else begin
                  rx_cnt <= rx_cnt + 5'h01;
               end
            end
            rpc_pkg::RPC_RX_PAY: begin
               rx_left <= rx_left - 16'h0001;
               if (rx_left == 16'h0001) begin
                  rx_state <= rpc_pkg::RPC_RX_HDR;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_pay_valid <= 1'b0;
         rx_pay_data  <= 8'h00;
         rx_pay_last  <= 1'b0;
      end else if (rx_take && (rx_state == rpc_pkg::RPC_RX_PAY)) begin
         rx_pay_valid <= 1'b1;
         rx_pay_data  <= link_rx_data;
         rx_pay_last  <= (rx_left == 16'h0001);
      end else if (rx_pay_ready) begin
         rx_pay_valid <= 1'b0;
         rx_pay_last  <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_hdr_valid <= 1'b0;
      end else begin
         rx_hdr_valid <= rx_hdr_stb;
      end
   end

   // fields hold from one header to the next; spare bits are dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_version               <= '0;
         rx_unordered             <= 1'b0;
         rx_prio                  <= '0;
         rx_control_data_flag     <= 1'b0;
         rx_vc_id                 <= '0;
         rx_vendor_extension_flag <= 1'b0;
         rx_payload_protocol_code <= '0;
         rx_reply_flag            <= 1'b0;
         rx_ack_valid_flag        <= 1'b0;
         rx_command               <= '0;
         rx_length                <= '0;
         rx_seq                   <= '0;
         rx_ack_seq               <= '0;
         rx_channel_time_stamp    <= '0;
      end else if (rx_hdr_stb) begin
         rx_version               <= rx_hdr_now.version;
         rx_unordered             <= rx_hdr_now.unordered;
         rx_prio                  <= rx_hdr_now.prio;
         // channel setup requests from clients arrive as control requests
         rx_control_data_flag     <= rx_hdr_now.control_data_flag;
         rx_vc_id                 <= rx_hdr_now.vc_id;
         rx_vendor_extension_flag <= rx_hdr_now.vendor_extension_flag;
         rx_payload_protocol_code <= rx_hdr_now.payload_protocol_code;
         rx_reply_flag            <= rx_hdr_now.reply_flag;
         rx_ack_valid_flag        <= rx_hdr_now.ack_valid_flag;
         rx_command               <= rx_hdr_now.command;
         rx_length                <= rx_hdr_now.length;
         rx_seq                   <= rx_hdr_now.seq;
         rx_ack_seq               <= rx_hdr_now.ack_valid_flag ?
                                     rx_hdr_now.ack_seq : '0;
         rx_channel_time_stamp    <= rx_hdr_now.channel_time_stamp;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_ver_err       <= 1'b0;
         rx_proto_unknown <= 1'b0;
         rx_len_err       <= 1'b0;
      end else if (rx_hdr_stb) begin
         rx_ver_err       <= (rx_hdr_now.version != `RPC_VERSION_STD) &&
                             (rx_hdr_now.version != `RPC_VERSION_PRE);
         // vendor codes are opaque; only the standard space is checked
         rx_proto_unknown <= !rx_hdr_now.vendor_extension_flag &&
                             (rx_hdr_now.payload_protocol_code >= `RPC_NUM_STATIC);
         // oversize is flagged but the bytes are still consumed to keep framing
         rx_len_err       <= !len_ok(rx_hdr_now.length);
      end
   end

   rpc_rx_track u_track (
      .clk     (clk),
      .rst_n   (rst_n),
      .stb     (rx_hdr_stb),
      .vc_id   (rx_hdr_now.vc_id),
      .seq     (rx_hdr_now.seq),
      .stamp   (rx_hdr_now.channel_time_stamp),
      .seq_gap (rx_seq_gap),
      .ts_late (rx_ts_late)
   );

endmodule // rpc_codec

// ==== test/rpc_codec_assertions.sv ====
/*
 Port checker for rpc_codec.
 Assumes its clock and synchronous active-low reset.
*/
`timescale 1ns/1ps

module rpc_codec_assertions (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        tx_start,
   input wire logic        tx_unordered,
   input wire logic [2:0]  tx_prio,
   input wire logic        tx_control_data_flag,
   input wire logic [15:0] tx_length,
   input wire logic        tx_busy,
   input wire logic        tx_len_err,
   input wire logic        link_tx_valid,
   input wire logic [7:0]  link_tx_data,
   input wire logic        link_tx_last,
   input wire logic        link_tx_ready,
   input wire logic        rx_hdr_valid,
   input wire logic [23:0] rx_vc_id,
   input wire logic        rx_vendor_extension_flag,
   input wire logic [4:0]  rx_payload_protocol_code,
   input wire logic        rx_ack_valid_flag,
   input wire logic [15:0] rx_ack_seq,
   input wire logic [2:0]  rx_version,
   input wire logic        rx_ver_err,
   input wire logic        rx_proto_unknown,
   input wire logic        rx_pay_valid,
   input wire logic [7:0]  rx_pay_data,
   input wire logic        rx_pay_ready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_LEN_REFUSE: assert property (tx_start && !tx_busy && tx_length > 16'hFA00
      && !link_tx_valid |=> tx_len_err && !tx_busy ##1 !link_tx_valid) else $error("oversize");
   AST_LEN_OK: assert property (tx_start && !tx_busy && tx_length <= 16'hFA00 |=>
      tx_busy && !tx_len_err) else $error("start lost");
   AST_FIRST_BYTE: assert property (tx_start && !tx_busy && tx_length <= 16'hFA00
      && !link_tx_valid |-> ##2 link_tx_valid && link_tx_data == {3'h1,
      $past(tx_unordered, 2), $past(tx_prio, 2), $past(tx_control_data_flag, 2)})
      else $error("first byte");
   AST_ACK_ZERO: assert property (rx_hdr_valid && !rx_ack_valid_flag |-> rx_ack_seq == '0)
      else $error("ack seq shown");
   AST_PROTO_UNK: assert property (rx_hdr_valid |-> rx_proto_unknown ==
      (!rx_vendor_extension_flag && rx_payload_protocol_code >= 5'h09))
      else $error("proto flag");
   AST_VER_ERR: assert property (rx_hdr_valid |-> rx_ver_err == (rx_version > 3'h1))
      else $error("version flag");
   AST_TX_HOLD: assert property (link_tx_valid && !link_tx_ready |=> link_tx_valid
      && $stable(link_tx_data) && $stable(link_tx_last)) else $error("link hold");
   AST_RX_HOLD: assert property (rx_pay_valid && !rx_pay_ready |=> rx_pay_valid
      && $stable(rx_pay_data)) else $error("pay hold");
   AST_VC_HOLD: assert property (!rx_hdr_valid |-> $stable(rx_vc_id))
      else $error("vc id moved");
endmodule // rpc_codec_assertions

bind rpc_codec rpc_codec_assertions i_rpc_codec_assertions (.*);

// ==== test/rpc_link_peer.sv ====
/*
 Far node as a one-byte loopback of link bytes.
 Assumes one clock; slow mode takes a byte every other cycle.
*/
`timescale 1ns/1ps

module rpc_link_peer (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       slow,
   input  wire logic       in_valid,
   input  wire logic [7:0] in_data,
   output logic            in_ready,
   output logic            out_valid,
   output logic [7:0]      out_data,
   input  wire logic       out_ready
);
   logic       full;
   logic       tick;
   logic [7:0] b;

   assign in_ready  = !full && !(slow && tick);
   assign out_valid = full;
   // idle data is scrambled so a stale byte never looks valid
   assign out_data  = full ? b : ~b;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         full <= 1'b0;
         tick <= 1'b0;
         b    <= 8'h00;
      end else begin
         tick <= !tick;
         if (in_valid && in_ready) begin
            full <= 1'b1;
            b    <= in_data;
         end else if (out_ready) begin
            full <= 1'b0;
         end
      end
   end
endmodule // rpc_link_peer

// ==== test/rpc_codec_bench.sv ====
/*
 Bench for rpc_codec: PDUs loop through a peer model back in.
 Assumes the 17-byte header layout of rpc_hdr_t.
*/
`timescale 1ns/1ps

module rpc_codec_bench;
   logic clk = 1'b0, rst_n = 1'b0, tx_start = 1'b0, stall = 1'b0, hs = 1'b0;
   logic tx_pay_valid = 1'b1, rx_pay_ready = 1'b1;
   logic [7:0] tx_pay_data = 8'h00;
   rpc_pkg::rpc_hdr_t h = '0;
   int miscompares = 0, n_tests = 0;
   logic [8:0] wq[$], rq[$];
   logic tx_busy, tx_len_err, tx_pay_ready, link_tx_valid, link_tx_last, link_tx_ready;
   logic link_rx_valid, link_rx_ready, rx_hdr_valid, rx_unordered, rx_control_data_flag;
   logic rx_vendor_extension_flag, rx_reply_flag, rx_ack_valid_flag, rx_ver_err;
   logic rx_proto_unknown, rx_len_err, rx_seq_gap, rx_ts_late, rx_pay_valid, rx_pay_last;
   logic [7:0] link_tx_data, link_rx_data, rx_pay_data;
   logic [2:0] rx_version, rx_prio;
   logic [4:0] rx_payload_protocol_code, rx_command;
   logic [15:0] rx_length, rx_seq, rx_ack_seq;
   logic [23:0] rx_vc_id;
   logic [31:0] rx_channel_time_stamp;

   rpc_codec i_rpc_codec (.*, .tx_unordered(h.unordered), .tx_prio(h.prio),
      .tx_control_data_flag(h.control_data_flag), .tx_vc_id(h.vc_id),
      .tx_vendor_extension_flag(h.vendor_extension_flag), .tx_command(h.command),
      .tx_payload_protocol_code(h.payload_protocol_code), .tx_reply_flag(h.reply_flag),
      .tx_ack_valid_flag(h.ack_valid_flag), .tx_length(h.length), .tx_seq(h.seq),
      .tx_ack_seq(h.ack_seq), .tx_channel_time_stamp(h.channel_time_stamp));
   rpc_link_peer i_rpc_link_peer (.clk(clk), .rst_n(rst_n), .slow(stall),
      .in_valid(link_tx_valid), .in_data(link_tx_data), .in_ready(link_tx_ready),
      .out_valid(link_rx_valid), .out_data(link_rx_data), .out_ready(link_rx_ready));

   always #50 clk = ~clk;

   always @(posedge clk) begin
      hs = tx_pay_valid && tx_pay_ready;
      if (link_tx_valid && link_tx_ready) wq.push_back({link_tx_last, link_tx_data});
      if (rx_pay_valid && rx_pay_ready) rq.push_back({rx_pay_last, rx_pay_data});
      #1;
      if (hs) tx_pay_data = tx_pay_data + 8'h01;
      rx_pay_ready = !stall || !rx_pay_ready;
   end

   task automatic chk(string nm, logic [135:0] seen, logic [135:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic kick(rpc_pkg::rpc_hdr_t hd);
      wq.delete();
      rq.delete();
      h = hd;
      tx_start = 1'b1;
      @(posedge clk);
      #1;
      tx_start = 1'b0;
   endtask

   // fl is {version, protocol, length, gap, late} error flags
   task automatic send(rpc_pkg::rpc_hdr_t hd, logic [4:0] fl);
      rpc_pkg::rpc_hdr_t e;
      logic [7:0] p0;
      int i;
      e = hd;
      e.version = 3'h1;
      e.spare_a = '0;
      e.spare_b = '0;
      if (!hd.ack_valid_flag) e.ack_seq = '0;
      p0 = tx_pay_data;
      kick(hd);
      for (i = 0; rx_hdr_valid !== 1'b1 && i < 200; i++) @(posedge clk) #1;
      chk("rx header", {rx_version, rx_unordered, rx_prio, rx_control_data_flag, rx_vc_id,
         2'h0, rx_vendor_extension_flag, rx_payload_protocol_code, 9'h000, rx_reply_flag,
         rx_ack_valid_flag, rx_command, rx_length, rx_seq, rx_ack_seq, rx_channel_time_stamp}, e);
      chk("rx flags", {rx_ver_err, rx_proto_unknown, rx_len_err, rx_seq_gap,
         rx_ts_late}, fl);
      for (i = 0; (rq.size() < hd.length || wq.size() < 17 + hd.length) && i < 400; i++)
         @(posedge clk) #1;
      for (i = 0; i < 17; i++)
         chk("link byte", wq[i], {i == 16 && hd.length == 0, e[135 - 8 * i -: 8]});
      for (i = 0; i < hd.length; i++) begin
         chk("link payload", wq[17 + i], {i == hd.length - 1, p0 + 8'(i)});
         chk("rx payload", rq[i], {i == hd.length - 1, p0 + 8'(i)});
      end
   endtask

   initial begin
      rpc_pkg::rpc_hdr_t g;
      int k;
      // junk version and spares must not reach the wire
      g = '1;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      for (k = 0; k < 11; k++) begin
         stall = k[0];
         g.vc_id = 24'h100000 + 24'(k);
         g.payload_protocol_code = 5'(k);
         g.vendor_extension_flag = (k == 10);
         {g.unordered, g.reply_flag, g.ack_valid_flag, g.control_data_flag} = 4'(k);
         g.length = 16'(k % 3);
         g.command = 5'(k);
         g.prio = 3'(k);
         g.seq = 16'h0100 + 16'(k);
         g.ack_seq = 16'hBE00 + 16'(k);
         g.channel_time_stamp = 32'(k) << 24;
         send(g, {1'b0, k == 9, 3'h0});
      end
      g.length = 16'hFA01;
      kick(g);
      chk("oversize refused", {tx_len_err, tx_busy}, 2'b10);
      repeat (3) @(posedge clk) #1;
      chk("oversize bytes", wq.size(), 0);
      g.length = 16'hFA00;
      kick(g);
      chk("largest taken", {tx_len_err, tx_busy}, 2'b01);
      repeat (30) @(posedge clk);
      #1;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk("after reset", {tx_busy, link_tx_valid, rx_hdr_valid}, 3'b000);
      g.length = 16'h0001;
      g.vc_id = 24'h00ABCD;
      for (k = 0; k < 3; k++) begin
         g.seq = (k == 0) ? 16'h5 : 16'h6 + 16'(k);
         g.channel_time_stamp = (k == 0) ? 32'h64 : 32'h28 + 32'(10 * k);
         send(g, {3'h0, k == 1, k == 1});
      end
      close_out();
   end

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out();
   end
endmodule // rpc_codec_bench
